// *** verilog/irq_map.svh ***
// Purpose: offsets, field positions, codes and reset values of the event interrupt block
// Assumes: 4-bit word address, 16-bit register data
// Notes: definitions only
//
// Contract
// - sixteen event sources are monitored
// - done events muted in continuous conversion
// - per-event enable bit gates each event
// - output gives pulse or level while active
// - pulse mode auto-disables event until re-enabled
// - pin polarity active high or low
// - status readable, output routable to pin
// - comparator enable bit, disabled means idle
// - update select 00 clock, 01 ch0, 10 ch1
// - code 11, continuous both: after pair done
// - code 11 otherwise: after every conversion
// - filter needs three consecutive true checks
// - compare 10-bit operands, 01 equal, 10 greater
// - operand from fixed value or 9-bit result
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH

`define ADDR_W 4
`define DATA_W 16
`define NUM_EVT 16

`define OFS_EVT_EN 4'h0
`define OFS_REEN 4'h1
`define OFS_CTRL 4'h2
`define OFS_STATUS 4'h3
`define OFS_MASK 4'h4
`define OFS_CMP_CFG 4'h5
`define OFS_CMP_FIX 4'h6
`define OFS_EVT_RAW 4'h7

`define CTRL_GLOBAL 0
`define CTRL_PULSE 1
`define CTRL_AUTO 2
`define CTRL_POL 3
`define CTRL_ROUTE 4

`define CFG_EN 0
`define CFG_UPD_LO 1
`define CFG_TYPE_LO 3
`define CFG_SELA_LO 5
`define CFG_SELB_LO 7
`define CFG_FILT 9

`define EVT_WAKE 4
`define EVT_CMP 12
`define EVT_DONE_A 13
`define EVT_DONE_B 14

`define UPD_CLOCK 2'h0
`define UPD_CH0 2'h1
`define UPD_CH1 2'h2
`define UPD_ADC 2'h3

`define TYPE_LT 2'h0
`define TYPE_EQ 2'h1
`define TYPE_GT 2'h2
`define TYPE_LE 2'h3

`define FILT_HITS 2'h3
`define RST_WORD 16'h0000
`define RST_FIX 10'h000

`endif

// *** verilog/irq_pkg.sv ***
// Purpose: state types of the event interrupt block and its comparator
// Assumes: widths fixed
// Notes: types only
package irq_pkg;

    typedef struct packed {
        logic [15:0] evt_en;
        logic [15:0] evt_dis;
        logic glob;
        logic pulse;
        logic auto_dis;
        logic pol;
        logic route;
        logic [15:0] status;
        logic [15:0] mask;
        logic [9:0] cmp_cfg;
        logic [9:0] cmp_fix;
        logic [15:0] prev;
        logic wake_s0;
        logic wake_s1;
        logic out;
        logic pin;
        logic irq;
        logic [15:0] rdata;
    } irq_state_t;

    typedef struct packed {
        logic result;
        logic [1:0] hits;
    } cmp_state_t;

endpackage : irq_pkg

// *** verilog/dig_cmp.sv ***
// Purpose: digital comparator with update select and three-check filter
// Assumes: conversion strobes are one-cycle pulses on ref_clk
// Notes: result registered
`timescale 1ns/10ps
`include "irq_map.svh"
module dig_cmp (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic cmp_enable,
    input wire logic [1:0] cmp_update_sel,
    input wire logic [1:0] cmp_type_sel,
    input wire logic [1:0] cmp_operand_sel_a,
    input wire logic [1:0] cmp_operand_sel_b,
    input wire logic cmp_filter_en,
    input wire logic [9:0] cmp_fixed_value,
    input wire logic [8:0] conv_result_ch0,
    input wire logic [8:0] conv_result_ch1,
    input wire logic conv_done_ch0,
    input wire logic conv_done_ch1,
    input wire logic adc_cont_both,
    input wire logic adc_pair_done,
    output logic cmp_result
);
    irq_pkg::cmp_state_t s, s_next;
    logic [9:0] cmp_operand_a;
    logic [9:0] cmp_operand_b;
    logic strobe;
    logic cond;

    // operand pick: fixed value or zero-extended channel result
    function automatic logic [9:0] pick(input logic [1:0] sel, input logic [9:0] fix,
                                        input logic [8:0] r0, input logic [8:0] r1);
        if (!sel[1]) begin
            pick = fix;
        end else begin
            pick = sel[0] ? {1'b0, r1} : {1'b0, r0};
        end
    endfunction : pick

    assign cmp_operand_a = pick(cmp_operand_sel_a, cmp_fixed_value, conv_result_ch0, conv_result_ch1);
    assign cmp_operand_b = pick(cmp_operand_sel_b, cmp_fixed_value, conv_result_ch0, conv_result_ch1);

    always_comb begin
        case (cmp_update_sel)
            `UPD_CLOCK: strobe = 1'b1;
            `UPD_CH0: strobe = conv_done_ch0;
            `UPD_CH1: strobe = conv_done_ch1;
            `UPD_ADC: strobe = adc_cont_both ? adc_pair_done : (conv_done_ch0 | conv_done_ch1);
            default: strobe = 1'b0;
        endcase
        case (cmp_type_sel)
            `TYPE_LT: cond = cmp_operand_a < cmp_operand_b;
            `TYPE_EQ: cond = cmp_operand_a == cmp_operand_b;
            `TYPE_GT: cond = cmp_operand_a > cmp_operand_b;
            `TYPE_LE: cond = cmp_operand_a <= cmp_operand_b;
            default: cond = 1'b0;
        endcase
    end

    always_comb begin
        s_next = s;
        if (!cmp_enable) begin
            s_next.result = 1'b0;
            s_next.hits = 2'h0;
        end else if (strobe) begin
            if (cmp_filter_en) begin
                if (!cond) begin
                    s_next.hits = 2'h0;
                end else if (s.hits != `FILT_HITS) begin
                    s_next.hits = s.hits + 2'h1;
                end
                s_next.result = cond && (s_next.hits == `FILT_HITS);
            end else begin
                s_next.hits = 2'h0;
                s_next.result = cond;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= s_next;
        end
    end

    assign cmp_result = s.result;

    property p_cmp_off;
        @(posedge ref_clk) disable iff (!nrst) !cmp_enable |=> !cmp_result;
    endproperty
    a_cmp_off: assert property (p_cmp_off) else $error("comparator active while disabled");

    property p_ch0_hold;
        @(posedge ref_clk) disable iff (!nrst)
            cmp_enable && cmp_update_sel == `UPD_CH0 && !conv_done_ch0 && $past(cmp_enable) |=> $stable(cmp_result);
    endproperty
    a_ch0_hold: assert property (p_ch0_hold) else $error("result moved without channel 0 done");

    property p_pair_hold;
        @(posedge ref_clk) disable iff (!nrst)
            cmp_enable && cmp_update_sel == `UPD_ADC && adc_cont_both && !adc_pair_done |=> $stable(cmp_result);
    endproperty
    a_pair_hold: assert property (p_pair_hold) else $error("result moved before pair done");

    property p_each_conv;
        @(posedge ref_clk) disable iff (!nrst)
            cmp_enable && !cmp_filter_en && cmp_update_sel == `UPD_ADC && !adc_cont_both && conv_done_ch1
            |=> cmp_result == $past(cond);
    endproperty
    a_each_conv: assert property (p_each_conv) else $error("result not refreshed on conversion");

    property p_filter;
        @(posedge ref_clk) disable iff (!nrst)
            cmp_enable && cmp_filter_en && strobe && s.hits == 2'h0
            |=> !cmp_result;
    endproperty
    a_filter: assert property (p_filter) else $error("filter signalled after one check");

    property p_equal;
        @(posedge ref_clk) disable iff (!nrst)
            cmp_enable && !cmp_filter_en && strobe && cmp_type_sel == `TYPE_EQ
            |=> cmp_result == ($past(cmp_operand_a) == $past(cmp_operand_b));
    endproperty
    a_equal: assert property (p_equal) else $error("equal compare wrong");

    property p_less;
        @(posedge ref_clk) disable iff (!nrst)
            cmp_enable && !cmp_filter_en && strobe && cmp_type_sel == `TYPE_LT
            |=> cmp_result == ($past(cmp_operand_a) < $past(cmp_operand_b));
    endproperty
    a_less: assert property (p_less) else $error("less compare wrong");

    property p_operand;
        @(posedge ref_clk) disable iff (!nrst)
            cmp_operand_sel_a == 2'h3 |-> cmp_operand_a == {1'b0, conv_result_ch1};
    endproperty
    a_operand: assert property (p_operand) else $error("operand select wrong");

endmodule : dig_cmp

// *** verilog/irq_ctrl.sv ***
// Purpose: event interrupt controller with digital comparator and register port
// Assumes: event inputs are ref_clk domain except the wake pin
// Notes: irq_pin_out is the pin level, irq is the status interrupt
`timescale 1ns/10ps
`include "irq_map.svh"
module irq_ctrl (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic bridge1_ilimit_evt,
    input wire logic bridge2_ilimit_evt,
    input wire logic bridge3_ilimit_evt,
    input wire logic bridge4_ilimit_evt,
    input wire logic wake_pin_n,
    input wire logic reg_controller_ilimit_evt,
    input wire logic main_regulator_ilimit_evt,
    input wire logic lv_switch1_ilimit_evt,
    input wire logic lv_switch2_ilimit_evt,
    input wire logic thermal_warning_evt,
    input wire logic watchdog_warning_evt,
    input wire logic watchdog_expiry_evt,
    input wire logic aux_loop1_ilimit_evt,
    input wire logic [8:0] conv_result_ch0,
    input wire logic [8:0] conv_result_ch1,
    input wire logic conv_done_ch0,
    input wire logic conv_done_ch1,
    input wire logic adc_cont_ch0,
    input wire logic adc_cont_ch1,
    input wire logic adc_pair_done,
    output logic irq_pin_out,
    output logic irq_out,
    output logic irq
);
    irq_pkg::irq_state_t s, s_next;
    logic [15:0] ev;
    logic [15:0] rise;
    logic [15:0] fire;
    logic [15:0] live;
    logic comparator_evt;
    logic wr_evt_en;
    logic wr_reen;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;
    logic wr_cfg;
    logic wr_fix;

    function automatic logic hit(input logic strobe, input logic [3:0] a, input logic [3:0] ofs);
        hit = strobe && (a == ofs);
    endfunction : hit

    dig_cmp dig_cmp_inst (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .cmp_enable(s.cmp_cfg[`CFG_EN]),
        .cmp_update_sel(s.cmp_cfg[`CFG_UPD_LO +: 2]),
        .cmp_type_sel(s.cmp_cfg[`CFG_TYPE_LO +: 2]),
        .cmp_operand_sel_a(s.cmp_cfg[`CFG_SELA_LO +: 2]),
        .cmp_operand_sel_b(s.cmp_cfg[`CFG_SELB_LO +: 2]),
        .cmp_filter_en(s.cmp_cfg[`CFG_FILT]),
        .cmp_fixed_value(s.cmp_fix),
        .conv_result_ch0(conv_result_ch0),
        .conv_result_ch1(conv_result_ch1),
        .conv_done_ch0(conv_done_ch0),
        .conv_done_ch1(conv_done_ch1),
        .adc_cont_both(adc_cont_ch0 & adc_cont_ch1),
        .adc_pair_done(adc_pair_done),
        .cmp_result(comparator_evt)
    );

    // event vector, one bit per monitored source
    always_comb begin
        ev = {aux_loop1_ilimit_evt,
              conv_done_ch1 & ~adc_cont_ch1,
              conv_done_ch0 & ~adc_cont_ch0,
              comparator_evt,
              watchdog_expiry_evt,
              watchdog_warning_evt,
              thermal_warning_evt,
              lv_switch2_ilimit_evt,
              lv_switch1_ilimit_evt,
              main_regulator_ilimit_evt,
              reg_controller_ilimit_evt,
              ~s.wake_s1,
              bridge4_ilimit_evt,
              bridge3_ilimit_evt,
              bridge2_ilimit_evt,
              bridge1_ilimit_evt};
    end

    assign live = ev & s.evt_en & ~s.evt_dis;
    assign rise = ev & ~s.prev;
    assign fire = rise & s.evt_en & ~s.evt_dis;

    assign wr_evt_en = hit(wr, addr, `OFS_EVT_EN);
    assign wr_reen = hit(wr, addr, `OFS_REEN);
    assign wr_ctrl = hit(wr, addr, `OFS_CTRL);
    assign wr_status = hit(wr, addr, `OFS_STATUS);
    assign wr_mask = hit(wr, addr, `OFS_MASK);
    assign wr_cfg = hit(wr, addr, `OFS_CMP_CFG);
    assign wr_fix = hit(wr, addr, `OFS_CMP_FIX);

    always_comb begin
        s_next = s;
        s_next.wake_s0 = wake_pin_n;
        s_next.wake_s1 = s.wake_s0;
        s_next.prev = ev;
        if (wr_evt_en) begin
            s_next.evt_en = wdata;
        end
        if (wr_ctrl) begin
            s_next.glob = wdata[`CTRL_GLOBAL];
            s_next.pulse = wdata[`CTRL_PULSE];
            s_next.auto_dis = wdata[`CTRL_AUTO];
            s_next.pol = wdata[`CTRL_POL];
            s_next.route = wdata[`CTRL_ROUTE];
        end
        if (wr_mask) begin
            s_next.mask = wdata;
        end
        if (wr_cfg) begin
            s_next.cmp_cfg = wdata[9:0];
        end
        if (wr_fix) begin
            s_next.cmp_fix = wdata[9:0];
        end
        // re-enable clears, a new auto-disable in the same cycle wins
        if (wr_reen) begin
            s_next.evt_dis = s.evt_dis & ~wdata;
        end
        if (s.glob && s.pulse && s.auto_dis) begin
            s_next.evt_dis = s_next.evt_dis | fire;
        end
        // sticky status, set wins over write-one-to-clear
        if (wr_status) begin
            s_next.status = s.status & ~wdata;
        end
        s_next.status = s_next.status | fire;
        s_next.irq = |(s_next.status & s_next.mask);
        // pulse on a new enabled event, or level while one persists
        if (!s.glob) begin
            s_next.out = 1'b0;
        end else if (s.pulse) begin
            s_next.out = |fire;
        end else begin
            s_next.out = |live;
        end
        s_next.pin = s_next.pol ^ (s_next.route & s_next.out);
        s_next.rdata = `RST_WORD;
        if (rd) begin
            case (addr)
                `OFS_EVT_EN: s_next.rdata = s.evt_en;
                `OFS_REEN: s_next.rdata = s.evt_dis;
                `OFS_CTRL: s_next.rdata = {11'h000, s.route, s.pol, s.auto_dis, s.pulse, s.glob};
                `OFS_STATUS: s_next.rdata = s.status;
                `OFS_MASK: s_next.rdata = s.mask;
                `OFS_CMP_CFG: s_next.rdata = {6'h00, s.cmp_cfg};
                `OFS_CMP_FIX: s_next.rdata = {6'h00, s.cmp_fix};
                `OFS_EVT_RAW: s_next.rdata = ev;
                default: s_next.rdata = `RST_WORD;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.wake_s0 <= 1'b1;
            s.wake_s1 <= 1'b1;
            s.prev <= `RST_WORD;
        end else begin
            s <= s_next;
        end
    end

    assign rdata = s.rdata;
    assign irq_out = s.out;
    assign irq_pin_out = s.pin;
    assign irq = s.irq;

    property p_done_mute;
        @(posedge ref_clk) disable iff (!nrst)
            adc_cont_ch0
            |-> !ev[`EVT_DONE_A];
    endproperty
    a_done_mute: assert property (p_done_mute) else $error("done event seen in continuous mode");

    property p_wake;
        @(posedge ref_clk) disable iff (!nrst)
            !wake_pin_n ##1 !wake_pin_n ##1 !wake_pin_n |-> ev[`EVT_WAKE];
    endproperty
    a_wake: assert property (p_wake) else $error("wake pin low not seen");

    property p_off_quiet;
        @(posedge ref_clk) disable iff (!nrst)
            !s.pulse && live == 16'h0000
            |=> !irq_out;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("output active with no enabled event");

    property p_level;
        @(posedge ref_clk) disable iff (!nrst)
            s.glob && !s.pulse && live != 16'h0000
            |=> irq_out;
    endproperty
    a_level: assert property (p_level) else $error("level output dropped while active");

    property p_pulse;
        @(posedge ref_clk) disable iff (!nrst)
            s.glob && s.pulse && fire != 16'h0000 ##1 s.glob && s.pulse && fire == 16'h0000
            |-> irq_out ##1 !irq_out;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse not one cycle");

    property p_auto;
        @(posedge ref_clk) disable iff (!nrst)
            s.glob && s.pulse && s.auto_dis && fire != 16'h0000
            |=> (s.evt_dis & $past(fire)) == $past(fire);
    endproperty
    a_auto: assert property (p_auto) else $error("firing event not disabled");

    property p_reen;
        @(posedge ref_clk) disable iff (!nrst)
            wr_reen && (fire == 16'h0000 || !s.auto_dis)
            |=> (s.evt_dis & $past(wdata)) == 16'h0000;
    endproperty
    a_reen: assert property (p_reen) else $error("re-enable write ignored");

    property p_pol;
        @(posedge ref_clk) disable iff (!nrst)
            irq_pin_out == (s.pol ^ (s.route & irq_out));
    endproperty
    a_pol: assert property (p_pol) else $error("pin polarity wrong");

    property p_status;
        @(posedge ref_clk) disable iff (!nrst)
            fire != 16'h0000
            |=> (s.status & $past(fire)) == $past(fire);
    endproperty
    a_status: assert property (p_status) else $error("status bit not set");

    property p_rd_idle;
        @(posedge ref_clk) disable iff (!nrst)
            !rd
            |=> rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

    property p_glob_off;
        @(posedge ref_clk) disable iff (!nrst)
            !s.glob
            |=> !irq_out;
    endproperty
    a_glob_off: assert property (p_glob_off) else $error("output on while disabled");

    property p_en_wr;
        @(posedge ref_clk) disable iff (!nrst)
            wr_evt_en
            |=> s.evt_en == $past(wdata);
    endproperty
    a_en_wr: assert property (p_en_wr) else $error("enable write lost");

    property p_sticky;
        @(posedge ref_clk) disable iff (!nrst)
            !wr_status
            |=> (s.status & $past(s.status)) == $past(s.status);
    endproperty
    a_sticky: assert property (p_sticky) else $error("status bit lost");

    property p_rd_status;
        @(posedge ref_clk) disable iff (!nrst)
            rd && addr == `OFS_STATUS
            |=> rdata == $past(s.status);
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read wrong");

    property p_irq_lvl;
        @(posedge ref_clk) disable iff (!nrst)
            irq ==
            ((s.status & s.mask) != 16'h0000);
    endproperty
    a_irq_lvl: assert property (p_irq_lvl) else $error("irq level wrong");

    property p_wake_idle;
        @(posedge ref_clk) disable iff (!nrst)
            wake_pin_n ##1 wake_pin_n ##1 wake_pin_n
            |-> !ev[`EVT_WAKE];
    endproperty
    a_wake_idle: assert property (p_wake_idle) else $error("wake seen while pin high");

    property p_done_b;
        @(posedge ref_clk) disable iff (!nrst)
            adc_cont_ch1
            |-> !ev[`EVT_DONE_B];
    endproperty
    a_done_b: assert property (p_done_b) else $error("done event seen in continuous mode");

endmodule : irq_ctrl

// *** sim/host_model.sv ***
// Purpose: register port master standing in for the host firmware
// Assumes: one strobe per cycle, read data stand in the cycle after rd
// Notes: bus_write and bus_read are called from the testbench
`timescale 1ns/10ps
module host_model (
    input wire logic ref_clk,
    input wire logic [15:0] rdata,
    output logic [3:0] addr,
    output logic [15:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end

    // one-cycle write, idle lines show the inverse afterwards
    task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask : bus_write

    // one-cycle read, data taken inside the cycle after the strobe
    task automatic bus_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask : bus_read
endmodule : host_model

// *** sim/event_interrupt_and_digital_comparator_tb.sv ***
// Purpose: self-checking bench of the event interrupt block and comparator
// Assumes: host_model drives the register port
// Notes: events are held for four cycles, outputs counted over eight
`timescale 1ns/10ps
`include "irq_map.svh"
module event_interrupt_and_digital_comparator_tb;
    logic ref_clk;
    logic nrst;
    logic [15:0] evt;
    logic done0, done1, cont0, cont1, pair;
    logic [8:0] ch0, ch1;
    logic [3:0] addr;
    logic [15:0] wdata, rdata;
    logic wr, rd, irq_pin_out, irq_out, irq;
    int err_count, comparisons, cycles, a, b, c, cp, t, v;
    logic [2:0] tt [4] = '{3'b001, 3'b010, 3'b100, 3'b011};

    host_model host_model_inst (.ref_clk(ref_clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

    irq_ctrl irq_ctrl_inst (
        .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .bridge1_ilimit_evt(evt[0]), .bridge2_ilimit_evt(evt[1]), .bridge3_ilimit_evt(evt[2]),
        .bridge4_ilimit_evt(evt[3]), .wake_pin_n(~evt[4]), .reg_controller_ilimit_evt(evt[5]),
        .main_regulator_ilimit_evt(evt[6]), .lv_switch1_ilimit_evt(evt[7]), .lv_switch2_ilimit_evt(evt[8]),
        .thermal_warning_evt(evt[9]), .watchdog_warning_evt(evt[10]), .watchdog_expiry_evt(evt[11]),
        .aux_loop1_ilimit_evt(evt[15]), .conv_result_ch0(ch0), .conv_result_ch1(ch1),
        .conv_done_ch0(done0), .conv_done_ch1(done1), .adc_cont_ch0(cont0), .adc_cont_ch1(cont1),
        .adc_pair_done(pair), .irq_pin_out(irq_pin_out), .irq_out(irq_out), .irq(irq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            summarize();
        end
    end

    task automatic summarize;
        if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rchk(input string what, input logic [3:0] ad, input logic [15:0] exp);
        logic [15:0] d;
        host_model_inst.bus_read(ad, d);
        check(what, d, exp);
    endtask : rchk

    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : settle

    // raise one event for four cycles, count output-high and pin-equals-output cycles
    task automatic bump(input int bit_no, output int n, output int np);
        int k;
        n = 0;
        np = 0;
        @(posedge ref_clk);
        evt[bit_no] <= 1'b1;
        for (k = 0; k < 8; k++) begin
            @(posedge ref_clk);
            if (k == 3) evt[bit_no] <= 1'b0;
            #1;
            n += (irq_out === 1'b1);
            np += (irq_pin_out === irq_out);
        end
    endtask : bump

    function automatic logic [9:0] cf(input logic en, input logic [1:0] upd, input logic [1:0] typ,
                                      input logic [1:0] sa, input logic [1:0] sb, input logic filt);
        return {filt, sb, sa, typ, upd, en};
    endfunction : cf

    // program the comparator, give up to three strobes {pair, done1, done0}, check the event bit
    task automatic cmp_case(input logic [9:0] cfg, input logic [1:0] cont, input logic [8:0] seq,
                            input logic [8:0] r0, input logic e);
        logic [15:0] d;
        int k;
        @(posedge ref_clk);
        ch0 <= r0;
        {cont1, cont0} <= cont;
        host_model_inst.bus_write(`OFS_CMP_CFG, {6'h00, cfg});
        for (k = 0; k < 3; k++) begin
            @(posedge ref_clk);
            {pair, done1, done0} <= seq[3*k+:3];
            @(posedge ref_clk);
            {pair, done1, done0} <= 3'h0;
        end
        repeat (3) @(posedge ref_clk);
        host_model_inst.bus_read(`OFS_STATUS, d);
        check("cmp_evt", {15'h0000, d[12]}, {15'h0000, e});
        host_model_inst.bus_write(`OFS_CMP_CFG, 16'h0000);
        host_model_inst.bus_write(`OFS_STATUS, 16'hffff);
    endtask : cmp_case

    initial begin
        evt = 16'h0000;
        {pair, done1, done0} = 3'h0;
        {cont1, cont0} = 2'h0;
        ch0 = 9'h000;
        ch1 = 9'h006;
        nrst = 1'b0;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        for (a = 0; a < 9; a++) rchk("reset_reg", a[3:0], 16'h0000);
        check("idle_out", {13'h0000, irq_pin_out, irq_out, irq}, 16'h0000);
        host_model_inst.bus_write(4'h8, 16'hffff);
        rchk("unmapped", 4'h8, 16'h0000);
        host_model_inst.bus_write(`OFS_EVT_EN, 16'h0001);
        host_model_inst.bus_write(`OFS_CTRL, 16'h0011);
        bump(1, c, cp);
        check("disabled_evt", 16'(c), 16'h0000);
        bump(0, c, cp);
        check("level_out", 16'(c), 16'h0004);
        check("pin_high", 16'(cp), 16'h0008);
        rchk("status", `OFS_STATUS, 16'h0001);
        check("irq_unmasked", {15'h0000, irq}, 16'h0000);
        host_model_inst.bus_write(`OFS_MASK, 16'h0001);
        settle();
        check("irq_masked", {15'h0000, irq}, 16'h0001);
        host_model_inst.bus_write(`OFS_STATUS, 16'h0001);
        settle();
        check("irq_cleared", {15'h0000, irq}, 16'h0000);
        rchk("status_w1c", `OFS_STATUS, 16'h0000);
        host_model_inst.bus_write(`OFS_CTRL, 16'h0019);
        bump(0, c, cp);
        check("pin_low", 16'(cp), 16'h0000);
        host_model_inst.bus_write(`OFS_CTRL, 16'h0001);
        bump(0, c, cp);
        check("pin_unrouted", 16'(cp), 16'h0004);
        host_model_inst.bus_write(`OFS_CTRL, 16'h0017);
        bump(0, c, cp);
        check("pulse_auto", 16'(c), 16'h0001);
        rchk("auto_masked", `OFS_REEN, 16'h0001);
        bump(0, c, cp);
        check("auto_blocked", 16'(c), 16'h0000);
        host_model_inst.bus_write(`OFS_REEN, 16'h0001);
        bump(0, c, cp);
        check("reenabled", 16'(c), 16'h0001);
        host_model_inst.bus_write(`OFS_CTRL, 16'h0013);
        host_model_inst.bus_write(`OFS_REEN, 16'h0001);
        for (a = 0; a < 2; a++) begin
            bump(0, c, cp);
            check("pulse_free", 16'(c), 16'h0001);
        end
        host_model_inst.bus_write(`OFS_CTRL, 16'h0011);
        host_model_inst.bus_write(`OFS_EVT_EN, 16'hffff);
        host_model_inst.bus_write(`OFS_STATUS, 16'hffff);
        for (b = 0; b < 16; b++) begin
            if (b < 12 || b == 15) begin
                bump(b, c, cp);
                rchk("event_status", `OFS_STATUS, 16'h0001 << b);
                host_model_inst.bus_write(`OFS_STATUS, 16'hffff);
            end
        end
        for (a = 0; a < 2; a++) begin
            @(posedge ref_clk);
            {cont1, cont0} <= (a == 1) ? 2'h3 : 2'h0;
            @(posedge ref_clk);
            {done1, done0} <= 2'h3;
            @(posedge ref_clk);
            {done1, done0} <= 2'h0;
            settle();
            rchk("done_evt", `OFS_STATUS, (a == 1) ? 16'h0000 : 16'h6000);
            host_model_inst.bus_write(`OFS_STATUS, 16'hffff);
        end
        host_model_inst.bus_write(`OFS_CMP_FIX, 16'h0005);
        for (t = 0; t < 4; t++) begin
            for (v = 0; v < 3; v++) begin
                cmp_case(cf(1'b1, `UPD_CLOCK, t[1:0], 2'h2, 2'h0, 1'b0), 2'h0, 9'h000, 9'(4 + v), tt[t][v]);
            end
        end
        cmp_case(cf(1'b1, `UPD_CLOCK, `TYPE_GT, 2'h3, 2'h0, 1'b0), 2'h0, 9'h000, 9'h000, 1'b1);
        cmp_case(cf(1'b1, `UPD_CLOCK, `TYPE_LT, 2'h2, 2'h3, 1'b0), 2'h0, 9'h000, 9'h004, 1'b1);
        cmp_case(cf(1'b0, `UPD_CLOCK, `TYPE_GT, 2'h2, 2'h0, 1'b0), 2'h0, 9'h000, 9'h006, 1'b0);
        cmp_case(cf(1'b1, `UPD_CH0, `TYPE_GT, 2'h2, 2'h0, 1'b0), 2'h0, 9'h000, 9'h006, 1'b0);
        cmp_case(cf(1'b1, `UPD_CH0, `TYPE_GT, 2'h2, 2'h0, 1'b0), 2'h0, 9'h001, 9'h006, 1'b1);
        cmp_case(cf(1'b1, `UPD_CH1, `TYPE_GT, 2'h2, 2'h0, 1'b0), 2'h0, 9'h001, 9'h006, 1'b0);
        cmp_case(cf(1'b1, `UPD_CH1, `TYPE_GT, 2'h2, 2'h0, 1'b0), 2'h0, 9'h002, 9'h006, 1'b1);
        cmp_case(cf(1'b1, `UPD_ADC, `TYPE_GT, 2'h2, 2'h0, 1'b0), 2'h3, 9'h011, 9'h006, 1'b0);
        cmp_case(cf(1'b1, `UPD_ADC, `TYPE_GT, 2'h2, 2'h0, 1'b0), 2'h3, 9'h004, 9'h006, 1'b1);
        cmp_case(cf(1'b1, `UPD_ADC, `TYPE_GT, 2'h2, 2'h0, 1'b0), 2'h0, 9'h002, 9'h006, 1'b1);
        cmp_case(cf(1'b1, `UPD_CH0, `TYPE_GT, 2'h2, 2'h0, 1'b1), 2'h0, 9'h009, 9'h006, 1'b0);
        cmp_case(cf(1'b1, `UPD_CH0, `TYPE_GT, 2'h2, 2'h0, 1'b1), 2'h0, 9'h049, 9'h006, 1'b1);
        summarize();
    end
endmodule : event_interrupt_and_digital_comparator_tb
